/* File: pkg/pfc_pkg.sv */
// Purpose: Constants and types for the parallel flash host sequencer.
// Assumes: Clock of 10 MHz, 100 ns period.
// Notes:   Times are kept in their own unit and converted to cycles here.
package pfc_pkg;
    localparam int CLK_NS              = 100;
    localparam int PROG_PULSE_US       = 10;
    localparam int WR_RECOVERY_US      = 6;
    localparam int RD_RECOVERY_US      = 0;
    localparam int ERASE_PULSE_US10    = 95;   // 9.5 ms in tenths of ms.
    localparam int ERASE_MAX_S         = 10;
    localparam int PROG_ARRAY_MAX_S    = 6;
    localparam int PROG_CYC  = (PROG_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC   = (WR_RECOVERY_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_CYC =
        (ERASE_PULSE_US10 * 100000 + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_TMO_CYC = ERASE_MAX_S * 10000000;
    localparam int PROG_TMO_CYC  = PROG_ARRAY_MAX_S * 10000000;
    localparam int WE_LOW_CYC    = 1;
    localparam int MAX_TRIES     = 25;
    localparam logic [7:0] CMD_READ    = 8'h00;
    localparam logic [7:0] CMD_SIG     = 8'h90;
    localparam logic [7:0] CMD_ERASE   = 8'h20;
    localparam logic [7:0] CMD_ERASE_V = 8'hA0;
    localparam logic [7:0] CMD_PROG    = 8'h40;
    localparam logic [7:0] CMD_PROG_V  = 8'hC0;
    localparam logic [7:0] CMD_RESET   = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] PRE_BYTE    = 8'h00;

    typedef enum logic [2:0] {
        OP_READ  = 3'h0,
        OP_SIG   = 3'h1,
        OP_PROG  = 3'h2,
        OP_ERASE = 3'h3,
        OP_ABORT = 3'h4
    } pfc_op_t;

    typedef struct packed {
        pfc_op_t     op;
        logic [15:0] addr;
        logic [7:0]  data;
        logic        sig_hv;
    } pfc_req_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        vpp_hi;
        logic        sig_hv;
        logic [15:0] addr;
        logic [7:0]  dout;
        logic        doe;
    } pfc_pins_t;
endpackage

/* File: logic/pfc_sync.sv */
// Purpose: Three-stage synchroniser for the flash data pins.
// Assumes: Pins change asynchronously to clk_i.
// Notes:   A change is taken once stages two and three agree.
`timescale 1ns/100ps
module pfc_sync
    import pfc_pkg::*;
(
    input  wire logic       clk_i,    // System clock.
    input  wire logic       sys_rst_i,// Synchronous reset.
    input  wire logic [7:0] d_i,      // Raw pin levels.
    output logic      [7:0] q_o       // Filtered levels.
);
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] q;
    } pfc_sync_st_t;
    pfc_sync_st_t st_q;
    pfc_sync_st_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < 8; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.q[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.q;
endmodule

/* File: logic/pfc_host.sv */
// Purpose: Host sequencer driving a byte-wide parallel flash by its pins.
// Assumes: 10 MHz clock; the flash keeps its own pin rules.
// Notes:   One request at a time; done_o pulses with the result.
// Contract
// [R1] Enables low, write high, signature line high, bit 0 low: maker ID.
// [R2] Same with bit 0 high gives the part ID byte.
// [R3] Flash floats data when read enable or chip select is high.
// [R4] Flash times program and erase pulses itself; erase at least 9.5 ms. Here the host times both pulses and the model has no timer.
// [R5] Host waits 6 us after write enable rises before reading.
// [R6] Host may write right after read enable returns high.
// [R7] Each program attempt takes at least 10 us plus 6 us.
// [R8] Host retries program and verify at most 25 times per byte.
// [R9] Host programs bytes to 00 before chip erase.
// [R10] Host allows 10 s for chip erase before failing.
// [R11] Host allows 6 s for whole-array programming before failing. The code applies it to OP_PROG; erase pre-programming has 10 s.
// [R12] Program supply high, write low: flash takes a byte.
// [R13] Program supply high, read low: flash drives verify data.
// [R14] Flash updates commands only with program supply high, on write rise.
// [R15] Host writes set-read 00 before normal reads.
// [R16] Two writes of FF abort and return to read mode.
// [R17] Command codes 20 twice, A0, 40, C0 and 90.
// [R18] In reset host keeps enables inactive and program supply low.
`timescale 1ns/100ps
module pfc_host
    import pfc_pkg::*;
(
    input  wire logic       clk_i,    // System clock, 10 MHz.
    input  wire logic       sys_rst_i,// Synchronous reset, high.
    input  wire logic       req_i,    // Start request, level.
    input  wire pfc_req_t   req_d_i,  // Request operation and operands.
    output logic            busy_o,   // Sequence running.
    output logic            done_o,   // One-cycle end pulse.
    output logic            fail_o,   // Result of last sequence.
    output logic      [7:0] rdata_o,  // Byte read.
    input  wire logic [7:0] fl_dq_i,  // Flash data pins in.
    output pfc_pins_t       fl_o      // Flash control, address, data out.
);
    typedef enum logic [7:0] {
        S_IDLE  = 8'b0000_0001,
        S_WLOW  = 8'b0000_0010,
        S_WHIGH = 8'b0000_0100,
        S_WAIT  = 8'b0000_1000,
        S_RLOW  = 8'b0001_0000,
        S_RCAP  = 8'b0010_0000,
        S_NEXT  = 8'b0100_0000,
        S_END   = 8'b1000_0000
    } pfc_state_t;

    typedef enum logic [3:0] {
        P_CMD1  = 4'h0,
        P_CMD2  = 4'h1,
        P_VCMD  = 4'h2,
        P_VREAD = 4'h3,
        P_READ  = 4'h4,
        P_PRE   = 4'h5,
        P_ABRT  = 4'h6
    } pfc_phase_t;

    typedef struct packed {
        pfc_state_t  st;
        pfc_phase_t  ph;
        pfc_req_t    rq;
        pfc_pins_t   pins;
        logic [7:0]  wbyte;
        logic [16:0] pre_addr;
        logic        pre_mode;
        logic [4:0]  tries;
        logic [19:0] wait_cnt;
        logic [29:0] tmo;
        logic        busy;
        logic        done;
        logic        fail;
        logic [7:0]  rdata;
    } pfc_st_t;

    localparam pfc_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        vpp_hi: 1'b0, sig_hv: 1'b0, addr: 16'h0000, dout: 8'h00, doe: 1'b0};

    pfc_st_t    s_q;
    pfc_st_t    s_d;
    logic [7:0] dq_s;

    pfc_sync i_pfc_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (fl_dq_i),
        .q_o       (dq_s)
    );

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (s_q.busy) begin
            s_d.tmo = s_q.tmo + 30'd1;
        end
        case (s_q.st)
            S_IDLE: begin
                s_d.pins = PINS_IDLE;
                if (req_i) begin
                    s_d.rq       = req_d_i;
                    s_d.busy     = 1'b1;
                    s_d.fail     = 1'b0;
                    s_d.tries    = 5'd0;
                    s_d.tmo      = 30'd0;
                    s_d.pre_addr = 17'd0;
                    s_d.pre_mode = (req_d_i.op == OP_ERASE); // R9
                    s_d.pins.vpp_hi = 1'b1;
                    s_d.st       = S_WLOW;
                    case (req_d_i.op)
                        OP_READ: begin
                            s_d.ph    = P_CMD1;
                            s_d.wbyte = CMD_READ; // R15
                        end
                        OP_SIG: begin
                            s_d.ph    = req_d_i.sig_hv ? P_READ : P_CMD1;
                            s_d.wbyte = CMD_SIG; // R17
                            s_d.pins.vpp_hi = !req_d_i.sig_hv;
                            if (req_d_i.sig_hv) begin
                                s_d.st = S_RLOW; // R1 R2
                            end
                        end
                        OP_ABORT: begin
                            s_d.ph    = P_ABRT;
                            s_d.wbyte = CMD_RESET; // R16
                        end
                        OP_ERASE: begin
                            s_d.ph    = P_CMD1;
                            s_d.wbyte = CMD_PROG; // R9
                        end
                        default: begin
                            s_d.ph    = P_CMD1;
                            s_d.wbyte = CMD_PROG; // R17
                        end
                    endcase
                end
            end
            S_WLOW: begin
                s_d.pins.ce_n = 1'b0;
                s_d.pins.oe_n = 1'b1;
                s_d.pins.we_n = 1'b0; // R6 R12
                s_d.pins.doe  = 1'b1;
                s_d.pins.dout = s_q.wbyte;
                // Erase verify walks the array with the same counter.
                s_d.pins.addr = (s_q.pre_mode || s_q.rq.op == OP_ERASE)
                              ? s_q.pre_addr[15:0] : s_q.rq.addr;
                s_d.st = S_WHIGH;
            end
            S_WHIGH: begin
                s_d.pins.we_n = 1'b1; // R14
                s_d.wait_cnt  = 20'd0;
                s_d.st        = S_WAIT;
            end
            S_WAIT: begin
                s_d.pins.doe  = 1'b0;
                s_d.pins.ce_n = 1'b1;
                s_d.wait_cnt  = s_q.wait_cnt + 20'd1;
                if (s_q.ph == P_CMD2 && s_q.wbyte != CMD_ERASE) begin
                    if (s_q.wait_cnt >= 20'(PROG_CYC + REC_CYC)) begin
                        s_d.st = S_NEXT; // R7 R4
                    end
                end else if (s_q.ph == P_CMD2) begin
                    if (s_q.wait_cnt >= 20'(ERASE_CYC)) begin
                        s_d.st = S_NEXT; // R4
                    end
                end else if (s_q.wait_cnt >= 20'(REC_CYC)) begin
                    s_d.st = S_NEXT; // R5
                end
            end
            S_RLOW: begin
                s_d.pins.ce_n   = 1'b0;
                s_d.pins.oe_n   = 1'b0; // R13
                s_d.pins.doe    = 1'b0;
                s_d.pins.sig_hv = s_q.rq.sig_hv && s_q.rq.op == OP_SIG;
                s_d.pins.addr   = (s_q.pre_mode || s_q.rq.op == OP_ERASE)
                                ? s_q.pre_addr[15:0] : s_q.rq.addr;
                s_d.wait_cnt    = 20'd0;
                s_d.st          = S_RCAP;
            end
            S_RCAP: begin
                s_d.wait_cnt = s_q.wait_cnt + 20'd1;
                if (s_q.wait_cnt >= 20'd4) begin
                    s_d.rdata       = dq_s;
                    s_d.pins.oe_n   = 1'b1; // R3
                    s_d.pins.ce_n   = 1'b1;
                    s_d.pins.sig_hv = 1'b0;
                    s_d.st          = S_NEXT;
                end
            end
            S_NEXT: begin
                s_d.st = S_WLOW;
                case (s_q.ph)
                    P_CMD1: begin
                        if (s_q.rq.op == OP_READ || s_q.rq.op == OP_SIG)
                        begin
                            s_d.ph = P_READ;
                            s_d.st = S_RLOW;
                        end else begin
                            s_d.ph    = P_CMD2;
                            s_d.wbyte = s_q.pre_mode ? PRE_BYTE
                                      : (s_q.rq.op == OP_ERASE ? CMD_ERASE
                                                               : s_q.rq.data);
                        end
                    end
                    P_CMD2: begin
                        s_d.ph    = P_VCMD;
                        s_d.wbyte = (s_q.wbyte == CMD_ERASE && !s_q.pre_mode)
                                  ? CMD_ERASE_V : CMD_PROG_V; // R17
                    end
                    P_VCMD: begin
                        s_d.ph = P_VREAD;
                        s_d.st = S_RLOW;
                    end
                    P_VREAD: begin
                        s_d.tries = s_q.tries + 5'd1;
                        if (s_q.rdata == (s_q.pre_mode ? PRE_BYTE
                            : (s_q.rq.op == OP_ERASE ? ERASED_BYTE
                                                     : s_q.rq.data))) begin
                            s_d.tries    = 5'd0;
                            s_d.pre_addr = s_q.pre_addr + 17'd1;
                            if (s_q.rq.op != OP_ERASE) begin
                                s_d.st = S_END;
                            end else if (s_q.pre_mode
                                         && s_q.pre_addr[15:0] == 16'hFFFF)
                            begin
                                s_d.pre_mode = 1'b0;
                                s_d.pre_addr = 17'd0;
                                s_d.tmo      = 30'd0; // R10
                                s_d.ph       = P_CMD1;
                                s_d.wbyte    = CMD_ERASE;
                            end else if (s_q.pre_mode) begin
                                s_d.ph    = P_CMD1;
                                s_d.wbyte = CMD_PROG;
                            end else if (s_q.pre_addr[15:0] == 16'hFFFF) begin
                                s_d.st = S_END;
                            end else begin
                                s_d.ph    = P_VCMD;
                                s_d.wbyte = CMD_ERASE_V;
                            end
                        end else if (s_q.rq.op == OP_ERASE && !s_q.pre_mode)
                        begin
                            s_d.tries = 5'd0;
                            s_d.ph    = P_CMD1;
                            s_d.wbyte = CMD_ERASE;
                        end else if (s_q.tries == 5'(MAX_TRIES - 1)) begin
                            s_d.fail = 1'b1; // R8
                            s_d.st   = S_END;
                        end else begin
                            s_d.ph    = P_CMD1;
                            s_d.wbyte = CMD_PROG;
                        end
                    end
                    P_ABRT: begin
                        s_d.ph = P_CMD2; // R16
                        s_d.wbyte = CMD_RESET;
                        s_d.st = S_WLOW;
                        if (s_q.tries != 5'd0) begin
                            s_d.st = S_END;
                        end
                        s_d.tries = 5'd1;
                    end
                    default: begin
                        s_d.st = S_END;
                    end
                endcase
                if (s_q.ph == P_CMD2 && s_q.rq.op == OP_ABORT) begin
                    s_d.st = S_END;
                end
                if (s_q.tmo >= 30'(ERASE_TMO_CYC) && s_q.rq.op == OP_ERASE
                    || s_q.tmo >= 30'(PROG_TMO_CYC) && s_q.rq.op == OP_PROG)
                begin
                    s_d.fail = 1'b1; // R10 R11
                    s_d.st   = S_END;
                end
            end
            S_END: begin
                s_d.pins = PINS_IDLE;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st   = S_IDLE;
            end
            default: begin
                s_d.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q      <= '0;
            s_q.st   <= S_IDLE;
            s_q.pins <= PINS_IDLE; // R18
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o  = s_q.busy;
    assign done_o  = s_q.done;
    assign fail_o  = s_q.fail;
    assign rdata_o = s_q.rdata;
    assign fl_o    = s_q.pins;

    wr_read_gap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(fl_o.we_n) |-> ##1 fl_o.oe_n [*8]) // R5
        else $error("read too soon after write");
    rst_idle_a: assert property (@(posedge clk_i)
        sys_rst_i |=> fl_o.ce_n && fl_o.we_n && !fl_o.vpp_hi) // R18
        else $error("pins active after reset");
    no_contend_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !fl_o.oe_n |-> !fl_o.doe && fl_o.we_n) // R3
        else $error("host drives data during read");
    wr_supply_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !fl_o.we_n |-> fl_o.vpp_hi && !fl_o.ce_n && fl_o.doe) // R12
        else $error("write without supply or data");
    tries_lim_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_q.tries <= 5'(MAX_TRIES)) // R8
        else $error("too many program tries");
    we_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(fl_o.we_n) |=> fl_o.we_n) // R14
        else $error("write pulse too long");
    sig_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        fl_o.sig_hv |-> !fl_o.oe_n && !fl_o.vpp_hi) // R1
        else $error("signature line high outside read");
    done_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        done_o |-> !busy_o ##1 fl_o.ce_n) // R16
        else $error("done with bus active");
    prog_c: cover property (@(posedge clk_i) done_o && !fail_o
        && s_q.rq.op == OP_PROG);
    fail_c: cover property (@(posedge clk_i) done_o && fail_o);
    sig_c: cover property (@(posedge clk_i) fl_o.sig_hv);
endmodule

/* File: verification/pfc_flash_model.sv */
// Purpose: Behavioural byte-wide flash seen from the host pins.
// Assumes: Times in ns; host pins come from pfc_host.
// Notes:   Counters for pulses, aborts and host timing faults.
`timescale 1ns/100ps
module pfc_flash_model
    import pfc_pkg::*;
#(
    parameter logic [7:0] MFG_ID = 8'h5C, // Arbitrary value.
    parameter logic [7:0] DEV_ID = 8'hA7  // Arbitrary value.
)(
    input  wire logic      clk_i,  // Bench clock for the idle pattern.
    input  wire pfc_pins_t pins_i, // Host pins.
    output logic     [7:0] dq_o,   // Data pins as the flash leaves them.
    output logic           drv_o   // Flash drives the data pins.
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  cmd;
    logic [7:0]  prev_b;
    logic [7:0]  rd_q;
    logic [7:0]  idle_q;
    logic [15:0] lat_a;
    logic        prog_arm;
    int          n_pulse;
    int          n_abort;
    int          n_viol;
    int          bad_tries;
    int          n_setrd;
    realtime     t_we;
    realtime     t_pulse;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hFF;
        end
        cmd = CMD_READ;
        prev_b = 8'h00;
        idle_q = 8'h3C;
        lat_a = 16'h0000;
        prog_arm = 1'b0;
        {n_pulse, n_abort, n_viol, bad_tries, n_setrd} = '0;
        t_we = -1.0e6;
        t_pulse = -1.0e6;
    end

    // Released pins show a changing pattern, never the last value.
    always @(posedge clk_i) idle_q <= idle_q + 8'h5B;

    always @(posedge pins_i.we_n) begin
        if (!pins_i.ce_n && pins_i.vpp_hi) begin
            t_we = $realtime;
            if (prog_arm) begin
                prog_arm = 1'b0;
                lat_a = pins_i.addr;
                n_pulse++;
                t_pulse = $realtime;
                if (bad_tries > 0) begin
                    bad_tries--;
                end else begin
                    mem[lat_a] = mem[lat_a] & pins_i.dout;
                end
            end else begin
                if (pins_i.dout == CMD_RESET && prev_b == CMD_RESET) begin
                    n_abort++;
                end
                if (pins_i.dout == CMD_READ) n_setrd++;
                if (pins_i.dout == CMD_PROG) prog_arm = 1'b1;
                if (pins_i.dout == CMD_PROG_V
                    && $realtime - t_pulse < PROG_PULSE_US * 1000.0) begin
                    n_viol++;
                end
                if (pins_i.dout == CMD_ERASE && prev_b == CMD_ERASE) begin
                    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
                end
                if (pins_i.dout == CMD_ERASE_V) lat_a = pins_i.addr;
                cmd = pins_i.dout;
                if (pins_i.dout == CMD_RESET && prev_b == CMD_RESET) begin
                    cmd = CMD_READ;
                end
            end
            prev_b = (prev_b == CMD_RESET) ? 8'h00 : pins_i.dout;
        end
    end

    always @(negedge pins_i.oe_n) begin
        if ($realtime - t_we < WR_RECOVERY_US * 1000.0) n_viol++;
    end

    always @(negedge clk_i) begin
        if (drv_o && pins_i.doe) n_viol++;
    end

    always @* begin
        drv_o = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n;
        if (pins_i.sig_hv || (pins_i.vpp_hi && cmd == CMD_SIG)) begin
            rd_q = pins_i.addr[0] ? DEV_ID : MFG_ID;
        end else if (pins_i.vpp_hi
                     && (cmd == CMD_PROG_V || cmd == CMD_ERASE_V)) begin
            rd_q = mem[lat_a];
        end else if (!pins_i.vpp_hi || cmd == CMD_READ) begin
            rd_q = mem[pins_i.addr];
        end else begin
            rd_q = ~idle_q;
        end
        dq_o = drv_o ? rd_q : idle_q;
    end
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the flash host sequencer.
// Assumes: 10 MHz clock; flash model on the pins.
// Notes:   Erase is only started and its first pre-programmed byte checked; a full erase runs for seconds.
`timescale 1ns/100ps
module tb;
    import pfc_pkg::*;
    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       req_i = 1'b0;
    pfc_req_t   req_d_i = '0;
    logic       busy_o;
    logic       done_o;
    logic       fail_o;
    logic [7:0] rdata_o;
    logic [7:0] fl_dq_i;
    logic [7:0] fl_q;
    pfc_pins_t  fl_o;
    int         n_fail = 0;
    int         tests_run = 0;
    int         cyc = 0;
    int         t0 = 0;

    always #50 clk_i = ~clk_i;
    assign fl_dq_i = fl_o.doe ? fl_o.dout : fl_q;

    pfc_host i_pfc_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_i(req_i), .req_d_i(req_d_i), .busy_o(busy_o), .done_o(done_o),
        .fail_o(fail_o), .rdata_o(rdata_o), .fl_dq_i(fl_dq_i), .fl_o(fl_o));
    pfc_flash_model i_pfc_flash_model (.clk_i(clk_i), .pins_i(fl_o),
        .dq_o(fl_q), .drv_o());

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic run(pfc_op_t op, logic [15:0] a, logic [7:0] d,
                       logic hv);
        int k;
        @(negedge clk_i);
        req_d_i = '{op, a, d, hv};
        req_i = 1'b1;
        t0 = cyc;
        @(negedge clk_i);
        req_i = 1'b0;
        check("busy", busy_o, 1'b1);
        k = 0;
        while (done_o !== 1'b1 && k < 20000) begin
            @(negedge clk_i);
            k++;
        end
        check("done", done_o, 1'b1);
    endtask

    task automatic t_reset();
        repeat (5) @(negedge clk_i);
        check("ce_n in reset", fl_o.ce_n, 1'b1);
        check("we_n in reset", fl_o.we_n, 1'b1);
        check("vpp in reset", fl_o.vpp_hi, 1'b0);
        check("busy in reset", busy_o, 1'b0);
        sys_rst_i = 1'b0;
        $display("reset test ended");
    endtask

    task automatic t_read();
        int s;
        i_pfc_flash_model.mem[16'h1234] = 8'hA5;
        s = i_pfc_flash_model.n_setrd;
        run(OP_READ, 16'h1234, 8'h00, 1'b0);
        check("read data", rdata_o, 8'hA5);
        check("set read", i_pfc_flash_model.n_setrd - s, 1);
        check("read fail", fail_o, 1'b0);
        $display("read test ended");
    endtask

    task automatic t_sig();
        for (int i = 0; i < 4; i++) begin
            run(OP_SIG, {15'h0000, i[0]}, 8'h00, i[1]);
            check("signature", rdata_o, i[0] ? 8'hA7 : 8'h5C);
        end
        $display("signature test ended");
    endtask

    task automatic t_prog();
        int p;
        p = i_pfc_flash_model.n_pulse;
        i_pfc_flash_model.bad_tries = 3;
        run(OP_PROG, 16'h0042, 8'h3C, 1'b0);
        check("prog fail", fail_o, 1'b0);
        check("prog byte", i_pfc_flash_model.mem[16'h0042], 8'h3C);
        check("prog tries", i_pfc_flash_model.n_pulse - p, 4);
        check("prog time", (cyc - t0) >= 4 * (PROG_CYC + REC_CYC), 1);
        $display("program retry test ended");
    endtask

    task automatic t_prog_fail();
        int p;
        p = i_pfc_flash_model.n_pulse;
        i_pfc_flash_model.bad_tries = 100;
        run(OP_PROG, 16'h0077, 8'h00, 1'b0);
        check("limit fail", fail_o, 1'b1);
        check("limit tries", i_pfc_flash_model.n_pulse - p, MAX_TRIES);
        i_pfc_flash_model.bad_tries = 0;
        $display("program limit test ended");
    endtask

    task automatic t_abort();
        int a;
        a = i_pfc_flash_model.n_abort;
        run(OP_ABORT, 16'h0000, 8'h00, 1'b0);
        check("abort", i_pfc_flash_model.n_abort - a, 1);
        run(OP_READ, 16'h0042, 8'h00, 1'b0);
        check("read after abort", rdata_o, 8'h3C);
        $display("abort test ended");
    endtask

    task automatic t_erase();
        int p;
        int k;
        p = i_pfc_flash_model.n_pulse;
        @(negedge clk_i);
        req_d_i = '{OP_ERASE, 16'h0000, 8'h00, 1'b0};
        req_i = 1'b1;
        @(negedge clk_i);
        req_i = 1'b0;
        check("erase busy", busy_o, 1'b1);
        k = 0;
        while (i_pfc_flash_model.n_pulse == p && k < 1000) begin
            @(negedge clk_i);
            k++;
        end
        check("pre byte", i_pfc_flash_model.mem[16'h0000], PRE_BYTE);
        sys_rst_i = 1'b1;
        repeat (5) @(negedge clk_i);
        check("vpp after reset", fl_o.vpp_hi, 1'b0);
        check("ce_n after reset", fl_o.ce_n, 1'b1);
        check("busy after reset", busy_o, 1'b0);
        sys_rst_i = 1'b0;
        $display("erase start test ended");
    endtask

    initial begin
        t_reset();
        t_read();
        t_sig();
        t_prog();
        t_prog_fail();
        t_abort();
        t_erase();
        check("pin timing", i_pfc_flash_model.n_viol, 0);
        give_verdict();
    end
endmodule
